// ===== shared/fcs_pkg.sv
package fcs_pkg;
    // Register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_CMD = 8'h04;
    localparam logic [7:0] OFS_STAT = 8'h08;
    localparam logic [7:0] OFS_PARAM = 8'h0C;
    localparam logic [7:0] OFS_ISTAT = 8'h10;
    localparam logic [7:0] OFS_IMASK = 8'h14;
    // Address bit that selects the flash window
    localparam int FLASH_SEL_BIT = 12;
    // Array sizes: words per page, pages
    localparam int PW = 8;
    localparam int NPG = 8;
    localparam int FW = PW * NPG;
    // Command register fields
    localparam int KEY_LSB = 24;
    localparam int PAGE_LSB = 8;
    // Status register fields
    localparam int ST_READY = 0;
    localparam int ST_LOCK_ERROR_FLAG = 2;
    localparam int ST_PROGRAMMING_ERROR_FLAG = 3;
    localparam int ST_LOCK_LSB = 16;
    // Parameter register fields
    localparam int PSZ_LSB = 8;
    // Interrupt status bits
    localparam int IR_DONE = 0;
    localparam int IR_LOCK = 1;
    localparam int IR_PROG = 2;
    // Command codes
    localparam logic [5:0] CMD_NOP = 6'h00;
    localparam logic [5:0] CMD_WP = 6'h01;
    localparam logic [5:0] CMD_EP = 6'h02;
    localparam logic [5:0] CMD_CPB = 6'h03;
    localparam logic [5:0] CMD_LP = 6'h04;
    localparam logic [5:0] CMD_UP = 6'h05;
    localparam logic [5:0] CMD_EA = 6'h06;
    localparam logic [5:0] CMD_QPR = 6'h0C;
    localparam logic [5:0] CMD_QUICK_USER_PAGE_READ_CMD = 6'h0F;
    // Command execution time
    localparam int CLK_PERIOD_NS = 10;
    localparam int CMD_TIME_NS = 80;
    localparam int CMD_CYCLES = (CMD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [3:0] CMD_CNT = 4'(CMD_CYCLES);
    // AHB transfer types
    localparam logic [1:0] HT_IDLE = 2'h0;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_PEND = 2'b01,
        ST_BUSY = 2'b10,
        ST_DONE = 2'b11
    } fcs_st_type;

    typedef struct packed {
        logic valid;
        logic write;
        logic flash;
        logic [7:0] addr;
    } fcs_dph_type;

    typedef struct packed {
        fcs_st_type st;
        logic [3:0] cnt;
        logic ready;
        logic programming_error_flag;
        logic lock_error_flag;
        logic ctrl_en;
        logic [5:0] cmd;
        logic [2:0] page;
        logic [NPG-1:0] lock;
        logic [2:0] istat;
        logic [2:0] imask;
        logic irq;
        logic [31:0] rdata;
        fcs_dph_type dph;
        logic [2:0] bp1;
        logic [2:0] bp2;
        logic [PW-1:0][31:0] pb;
        logic [FW-1:0][31:0] flash;
    } fcs_state_type;
endpackage

// ===== rtl/fcs_sequencer.sv
`timescale 1ns/100ps
// Notes on behaviour
// RQ1 - Page buffer bits rise only by clear
// RQ2 - Page write leaves page buffer unchanged
// RQ3 - Command write clears ready flag at once; a write in the completion cycle or in ST_DONE leaves ready set
// RQ4 - Command completion sets ready flag again
// RQ5 - Enabled completion raises the interrupt request
// RQ6 - Quick page reads never request interrupt
// RQ7 - Flash reads stall while command executes
// RQ8 - Execution starts on first idle bus cycle
// RQ9 - Masters leave idle cycles, no endless bursts
// RQ10 - Software waits for ready before flash access
// RQ11 - Fixed key in top eight command bits
// RQ12 - Bad key or code sets programming error
// RQ13 - Command while busy sets programming error
// RQ14 - Status read clears both error flags
// RQ15 - Protected page write or erase: lock error
// RQ16 - Parameter register reports three-bit page size
// RQ17 - Key and valid codes are parameters
// RQ18 - Parameter register read-only, size code parameter
module fcs_sequencer
    import fcs_pkg::*;
#(
    parameter logic [7:0] KEY = 8'hA5, // Arbitrary value
    parameter logic [63:0] VALID_CMDS = 64'h0000_0000_0000_907F,
    parameter logic [2:0] PSZ_CODE = 3'h0,
    parameter logic [3:0] FSZ_CODE = 4'h0
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic ce,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic [2:0] boot_protect_fuses,
    output logic irq
);
    fcs_state_type s_q;
    fcs_state_type s_d;
    logic acc;
    logic wr_now;
    logic cmd_wr;
    logic key_ok;
    logic code_ok;
    logic quick;
    logic prot;
    logic done_now;
    logic [5:0] ra;
    logic [2:0] pi;

    // Stall flash reads in the data phase while a command runs
    assign hreadyout = !(s_q.dph.valid && s_q.dph.flash && !s_q.dph.write
        && s_q.st == ST_BUSY); // [RQ7]
    assign hresp = 1'b0;
    assign hrdata = s_q.rdata;
    assign irq = s_q.irq;

    // Bus decode helpers
    assign acc = hsel && htrans[1] && hready;
    assign wr_now = s_q.dph.valid && s_q.dph.write && hreadyout;
    assign cmd_wr = wr_now && !s_q.dph.flash && s_q.dph.addr == OFS_CMD;
    assign key_ok = hwdata[31:KEY_LSB] == KEY; // [RQ11] [RQ17]
    assign code_ok = VALID_CMDS[hwdata[5:0]]; // [RQ17]
    assign quick = s_q.cmd == CMD_QPR || s_q.cmd == CMD_QUICK_USER_PAGE_READ_CMD;
    assign done_now = s_q.st == ST_BUSY && s_q.cnt == 4'h1;
    assign prot = ((s_q.cmd == CMD_WP || s_q.cmd == CMD_EP)
        && (s_q.lock[s_q.page] || s_q.page < s_q.bp2))
        || (s_q.cmd == CMD_EA && (|s_q.lock || s_q.bp2 != 3'h0));

    // Next-state logic for the whole block
    always_comb begin
        s_d = s_q;
        ra = haddr[7:2];
        pi = s_q.dph.addr[4:2];
        s_d.bp1 = boot_protect_fuses;
        s_d.bp2 = s_q.bp1;
        if (hready) begin
            s_d.dph.valid = hsel && htrans[1];
            s_d.dph.write = hwrite;
            s_d.dph.flash = haddr[FLASH_SEL_BIT];
            s_d.dph.addr = haddr[7:0];
        end
        // Read data captured at address acceptance
        if (acc && !hwrite) begin
            s_d.rdata = 32'h0000_0000;
            if (haddr[FLASH_SEL_BIT]) begin
                s_d.rdata = s_q.flash[ra];
            end else begin
                case (haddr[7:0])
                    OFS_CTRL: s_d.rdata[0] = s_q.ctrl_en;
                    OFS_STAT: begin
                        s_d.rdata[ST_READY] = s_q.ready;
                        s_d.rdata[ST_LOCK_ERROR_FLAG] = s_q.lock_error_flag;
                        s_d.rdata[ST_PROGRAMMING_ERROR_FLAG] = s_q.programming_error_flag;
                        s_d.rdata[ST_LOCK_LSB +: NPG] = s_q.lock;
                        s_d.programming_error_flag = 1'b0; // [RQ14]
                        s_d.lock_error_flag = 1'b0; // [RQ14]
                    end
                    OFS_PARAM: begin
                        s_d.rdata[PSZ_LSB +: 3] = PSZ_CODE; // [RQ16]
                        s_d.rdata[3:0] = FSZ_CODE; // [RQ18]
                    end
                    OFS_ISTAT: begin
                        s_d.rdata[2:0] = s_q.istat;
                        s_d.istat = 3'h0;
                    end
                    OFS_IMASK: s_d.rdata[2:0] = s_q.imask;
                    default: s_d.rdata = 32'h0000_0000;
                endcase
            end
        end
        // Writes in the data phase
        if (wr_now && s_q.dph.flash) begin
            s_d.pb[pi] = s_q.pb[pi] & hwdata; // [RQ1]
        end else if (wr_now) begin
            case (s_q.dph.addr)
                OFS_CTRL: s_d.ctrl_en = hwdata[0];
                OFS_IMASK: s_d.imask = hwdata[2:0];
                OFS_CMD: begin
                    s_d.ready = 1'b0; // [RQ3]
                    if (s_q.st != ST_IDLE) begin
                        s_d.programming_error_flag = 1'b1; // [RQ13]
                        s_d.istat[IR_PROG] = 1'b1;
                    end else if (!key_ok || !code_ok) begin
                        s_d.programming_error_flag = 1'b1; // [RQ12]
                        s_d.istat[IR_PROG] = 1'b1;
                        s_d.st = ST_DONE;
                    end else begin
                        s_d.cmd = hwdata[5:0];
                        s_d.page = hwdata[PAGE_LSB +: 3];
                        s_d.st = ST_PEND;
                    end
                end
                default: s_d.ctrl_en = s_q.ctrl_en;
            endcase
        end
        // Command sequencing
        case (s_q.st)
            ST_PEND: begin
                if (htrans == HT_IDLE) begin // [RQ8]
                    if (prot) begin
                        s_d.lock_error_flag = 1'b1; // [RQ15]
                        s_d.istat[IR_LOCK] = 1'b1;
                        s_d.st = ST_DONE;
                    end else begin
                        s_d.st = ST_BUSY;
                        s_d.cnt = CMD_CNT;
                    end
                end
            end
            ST_BUSY: begin
                s_d.cnt = s_q.cnt - 4'h1;
                if (done_now) begin
                    s_d.ready = 1'b1; // [RQ4]
                    s_d.st = ST_IDLE;
                    if (s_q.ctrl_en && !quick) begin
                        s_d.istat[IR_DONE] = 1'b1; // [RQ5] [RQ6]
                    end
                    // Effects; page write keeps the page buffer [RQ2]
                    for (int w = 0; w < PW; w++) begin
                        case (s_q.cmd)
                            CMD_WP: s_d.flash[{s_q.page, 3'(w)}] =
                                s_q.flash[{s_q.page, 3'(w)}] & s_q.pb[w];
                            CMD_EP: s_d.flash[{s_q.page, 3'(w)}] = '1;
                            CMD_CPB: s_d.pb[w] = '1; // [RQ1]
                            default: s_d.pb[w] = s_q.pb[w];
                        endcase
                    end
                    case (s_q.cmd)
                        CMD_EA: s_d.flash = '1;
                        CMD_LP: s_d.lock[s_q.page] = 1'b1;
                        CMD_UP: s_d.lock[s_q.page] = 1'b0;
                        default: s_d.lock = s_q.lock;
                    endcase
                end
            end
            ST_DONE: begin
                s_d.ready = 1'b1;
                s_d.st = ST_IDLE;
            end
            // Idle keeps whatever the command write decided above
            default: s_d.cnt = s_q.cnt;
        endcase
        // Refresh a stalled flash read with post-command contents
        if (!hreadyout) begin
            s_d.rdata = s_d.flash[s_q.dph.addr[7:2]]; // [RQ7]
        end
        s_d.irq = |(s_d.istat & s_d.imask); // [RQ5]
    end

    // State register
    always_ff @(posedge clk) begin
        if (!nrst) begin
            s_q <= '0;
            s_q.st <= ST_IDLE;
            s_q.ready <= 1'b1;
            s_q.pb <= '1;
            s_q.flash <= '1;
        end else if (ce) begin
            s_q <= s_d;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst || !ce);

    sequence seq_cmd_wr;
        cmd_wr;
    endsequence
    sequence seq_done;
        done_now;
    endsequence

    chk_ready_clear: assert property (seq_cmd_wr |=> !s_q.ready) // [RQ3]
        else $error("ready not cleared by command write");
    chk_ready_set: assert property (seq_done |=> s_q.ready && s_q.st == ST_IDLE) // [RQ4]
        else $error("ready not set at completion");
    chk_irq_done: assert property (seq_done and s_q.ctrl_en && !quick
        |=> s_q.istat[IR_DONE] && (irq || !s_q.imask[IR_DONE])) // [RQ5]
        else $error("completion interrupt missing");
    chk_quick_noirq: assert property (seq_done and quick && !s_q.istat[IR_DONE]
        |=> !s_q.istat[IR_DONE]) // [RQ6]
        else $error("quick read raised interrupt");
    chk_stall_busy: assert property (s_q.dph.valid && s_q.dph.flash
        && !s_q.dph.write && s_q.st == ST_BUSY
        |-> !hreadyout ##[1:8] (hreadyout && s_q.st == ST_IDLE)) // [RQ7]
        else $error("flash read not stalled while busy");
    chk_start_idle: assert property (s_q.st == ST_PEND && htrans != HT_IDLE
        |=> s_q.st == ST_PEND) // [RQ8]
        else $error("command started on non-idle cycle");
    chk_bad_key: assert property (seq_cmd_wr and !key_ok
        |=> s_q.programming_error_flag && $stable(s_q.flash) ##1 s_q.ready) // [RQ12]
        else $error("bad key not flagged");
    chk_busy_programming_error_flag: assert property (seq_cmd_wr and s_q.st == ST_BUSY
        |=> s_q.programming_error_flag && s_q.st != ST_PEND) // [RQ13]
        else $error("busy command not flagged");
    chk_stat_clear: assert property (acc && !hwrite && haddr[7:0] == OFS_STAT
        && !haddr[FLASH_SEL_BIT] && !cmd_wr && s_q.st != ST_PEND
        |=> !s_q.programming_error_flag && !s_q.lock_error_flag) // [RQ14]
        else $error("status read did not clear errors");
    chk_lock_err: assert property (s_q.st == ST_PEND && htrans == HT_IDLE && prot
        |=> s_q.lock_error_flag && $stable(s_q.flash)) // [RQ15]
        else $error("protected page not refused");
    chk_pb_no_rise: assert property (!(done_now && s_q.cmd == CMD_CPB)
        |=> ((~$past(s_q.pb)) & s_q.pb) == '0) // [RQ1]
        else $error("page buffer bit rose without clear");
endmodule

// ===== tb/fcs_ahb_master.sv
`timescale 1ns/100ps
// Single-transfer bus master standing in for the processor
module fcs_ahb_master (
    input wire logic clk,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    output logic hsel,
    output logic [31:0] haddr,
    output logic [1:0] htrans,
    output logic hwrite,
    output logic [2:0] hsize,
    output logic [31:0] hwdata
);
    int fails = 0;
    int waits = 0;
    // Bus idle at time zero
    initial begin
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
    end
    // One word; the bus is left idle afterwards so a command can start
    task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
                        output logic [31:0] rd);
        int n;
        @(posedge clk);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= w;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (hready !== 1'b1 && n < 100);
        htrans <= 2'h0;
        hwdata <= d;
        waits = 0;
        do begin
            @(posedge clk);
            waits++;
        end while (hready !== 1'b1 && waits < 100);
        rd = hrdata;
        if (n >= 100 || waits >= 100) fails++;
        hsel <= 1'b0;
    endtask
endmodule

// ===== tb/fcs_sequencer_tb_top.sv
`timescale 1ns/100ps
// Bench for the command sequencer
module fcs_sequencer_tb_top;
    import fcs_pkg::*;
    localparam logic [7:0] TB_KEY = 8'hA5; // Arbitrary value
    typedef struct packed {logic [7:0] a; logic [31:0] e;} fcs_row_type;
    logic clk, nrst, hsel, hwrite, hreadyout, hresp, irq;
    logic [31:0] haddr, hwdata, hrdata, rd, acc;
    logic [1:0] htrans;
    logic [2:0] hsize, fuses;
    int mismatches = 0;
    int total_checks = 0;
    fcs_row_type rows [6] = '{'{OFS_CTRL, 32'h0}, '{OFS_STAT, 32'h1},
        '{OFS_PARAM, 32'h0503}, '{OFS_ISTAT, 32'h0}, '{OFS_IMASK, 32'h0}, '{8'h18, 32'h0}};
    logic [5:0] quick [2] = '{CMD_QPR, CMD_QUICK_USER_PAGE_READ_CMD};

    fcs_sequencer #(.KEY(TB_KEY), .PSZ_CODE(3'h5), .FSZ_CODE(4'h3)) i_fcs_sequencer (
        .clk(clk), .nrst(nrst), .ce(1'b1), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .boot_protect_fuses(fuses), .irq(irq));
    fcs_ahb_master i_fcs_ahb_master (.clk(clk), .hready(hreadyout), .hrdata(hrdata),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata));

    // Clock source
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wrap_up();
        mismatches += i_fcs_ahb_master.fails;
        $display("Checks %0d, mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic rw(input logic w, input logic [31:0] a, input logic [31:0] d);
        i_fcs_ahb_master.xfer(w, a, d, rd);
        // A bus wait that ran out ends the run as a failure
        if (i_fcs_ahb_master.fails > 0) begin
            wrap_up();
        end
    endtask
    function automatic logic [31:0] cmd(input logic [5:0] code, input logic [2:0] pg);
        return {TB_KEY, 13'h0, pg, 2'h0, code};
    endfunction
    // Issue a command and poll status until ready, gathering every status bit seen
    task automatic cmd_wait(input logic [31:0] c);
        int n;
        rw(1'b1, OFS_CMD, c);
        acc = 32'h0;
        n = 0;
        do begin
            rw(1'b0, OFS_STAT, 32'h0);
            acc |= rd;
            n++;
        end while (rd[0] !== 1'b1 && n < 40);
        if (n >= 40) begin
            mismatches++;
            wrap_up();
        end
    endtask

    // Main sequence
    initial begin
        nrst = 1'b0;
        fuses = 3'h0;
        repeat (8) @(posedge clk);
        nrst <= 1'b1;
        rw(1'b1, OFS_PARAM, 32'hFFFFFFFF);
        foreach (rows[i]) begin
            rw(1'b0, {24'h0, rows[i].a}, 32'h0);
            check(rd, rows[i].e);
        end
        rw(1'b1, OFS_CTRL, 32'h1);
        rw(1'b1, OFS_IMASK, 32'h1);
        rw(1'b1, 32'h1000, 32'hFFFF0000);
        rw(1'b1, OFS_CMD, cmd(CMD_WP, 3'h0));
        rw(1'b0, OFS_STAT, 32'h0);
        check(rd & 32'h1, 32'h0);
        rw(1'b0, 32'h1000, 32'h0);
        check(rd, 32'hFFFF0000);
        check(32'(hresp), 32'h0);
        check(32'(i_fcs_ahb_master.waits > 1), 32'h1);
        rw(1'b0, OFS_STAT, 32'h0);
        check(rd, 32'h1);
        check(32'(irq), 32'h1);
        rw(1'b0, OFS_ISTAT, 32'h0);
        check(rd, 32'h1);
        // Page buffer kept across a page write, restored only by clearing
        cmd_wait(cmd(CMD_WP, 3'h1));
        rw(1'b0, 32'h1020, 32'h0);
        check(rd, 32'hFFFF0000);
        cmd_wait(cmd(CMD_CPB, 3'h0));
        rw(1'b1, 32'h1000, 32'h0000FFFF);
        cmd_wait(cmd(CMD_WP, 3'h2));
        rw(1'b0, 32'h1040, 32'h0);
        check(rd, 32'h0000FFFF);
        rw(1'b0, OFS_ISTAT, 32'h0);
        foreach (quick[i]) begin
            cmd_wait(cmd(quick[i], 3'h0));
            rw(1'b0, OFS_ISTAT, 32'h0);
            check(rd, 32'h0);
            check(32'(irq), 32'h0);
        end
        // Refused commands leave the array alone
        cmd_wait(cmd(CMD_WP, 3'h3) ^ 32'hFF000000);
        check(acc & 32'h8, 32'h8);
        cmd_wait(cmd(6'h07, 3'h3));
        check(acc & 32'h8, 32'h8);
        rw(1'b0, 32'h1060, 32'h0);
        check(rd, 32'hFFFFFFFF);
        rw(1'b1, OFS_CMD, cmd(CMD_WP, 3'h5));
        cmd_wait(cmd(CMD_WP, 3'h6));
        check(acc & 32'h8, 32'h8);
        rw(1'b0, OFS_STAT, 32'h0);
        check(rd & 32'hC, 32'h0);
        rw(1'b0, 32'h10C0, 32'h0);
        check(rd, 32'hFFFFFFFF);
        // Locked page, then a page under the boot fuses
        cmd_wait(cmd(CMD_LP, 3'h4));
        cmd_wait(cmd(CMD_WP, 3'h4));
        check(acc & 32'h00100004, 32'h00100004);
        rw(1'b0, 32'h1080, 32'h0);
        check(rd, 32'hFFFFFFFF);
        fuses <= 3'h2;
        cmd_wait(cmd(CMD_EP, 3'h1));
        check(acc & 32'h4, 32'h4);
        rw(1'b0, 32'h1020, 32'h0);
        check(rd, 32'hFFFF0000);
        wrap_up();
    end
endmodule
